// ### hw/tpp_pkg.sv
// Constants, register map and field layout of the timed pulse pattern block
// Summary of operation
// - On each output trigger every next-data bit of the triggered group whose enable bit is 1 is copied into the output data register.
// - Output data bits whose enable bit is 0 are left unchanged by the output trigger.
// - Software writes to an output data bit are ignored while its enable bit is 1.
// - Software writes to an output data bit are accepted while its enable bit is 0, to preset the pulse level.
// - The low four next-data bits move to the output data register on the trigger chosen by the group 0 select.
// - Counter 0 counts while its run bit is 1 and holds its value while the run bit is 0.
// - With the clear select at 010 counter 0 is cleared on a compare B match.
// - With the edge select at 00 the counter advances on falling internal edges or rising external edges.
// - With the prescale select at 010 the counter is clocked from the system clock divided by sixteen.
// - The compare A interrupt is raised only while the compare A flag and its enable bit are both 1.
// - The compare B flag is set to 1 on a compare B match and stays 1 until software writes 1 to it.
// - The compare A flag is set to 1 on a compare A match and stays 1 until software writes 1 to it.
// - Compare registers A and B are 16 bits wide and are compared with counter 0 at each count tick while it runs.
// - With the group 0 trigger field at 00 a compare A match of timer channel 0 triggers output group 0.
`default_nettype none
package tpp_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // Register byte addresses
  localparam logic [23:0] ADR_MATCH_FLAGS = 24'hFFFFD5;
  localparam logic [23:0] ADR_COMPARE_A   = 24'hFFFFD8;
  localparam logic [23:0] ADR_COMPARE_B   = 24'hFFFFDA;
  localparam logic [23:0] ADR_NEXT_ENABLE = 24'hFFFFC0;
  localparam logic [23:0] ADR_OUTPUT_DATA = 24'hFFFFC1;
  localparam logic [23:0] ADR_NEXT_VALUE  = 24'hFFFFC2;
  localparam logic [23:0] ADR_TRIG_SELECT = 24'hFFFFC3;
  localparam logic [23:0] ADR_RUN_CONTROL = 24'hFFFFC4;
  localparam logic [23:0] ADR_CONTROL     = 24'hFFFFC5;
  localparam logic [23:0] ADR_IRQ_ENABLE  = 24'hFFFFC6;
  // Reset values
  localparam logic [15:0] RST_COMPARE     = 16'hFFFF;
  localparam logic [7:0]  RST_TRIG_SELECT = 8'hFF;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  // Field positions
  localparam int FLAG_A     = 0;
  localparam int FLAG_B     = 1;
  localparam int RUN_BIT    = 0;
  localparam int COUNTER_CLEAR_SELECT_LSB   = 5;
  localparam int CLOCK_EDGE_SELECT_LSB   = 3;
  localparam int PRESCALE_SELECT_LSB   = 0;
  localparam int GRP_FIELDS = 2;
  localparam int GRP_BITS   = 4;
  // Field encodings
  localparam logic [2:0] COUNTER_CLEAR_SELECT_NONE = 3'h0;
  localparam logic [2:0] COUNTER_CLEAR_SELECT_A    = 3'h1;
  localparam logic [2:0] COUNTER_CLEAR_SELECT_B    = 3'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [2:0] PSC_1     = 3'h0;
  localparam logic [2:0] PSC_4     = 3'h1;
  localparam logic [2:0] PSC_16    = 3'h2;
  localparam logic [2:0] PSC_64    = 3'h3;
  localparam logic [1:0] TRIG_CH0  = 2'h0;
  // Prescaler bit whose edges give each division
  localparam int PRE_W      = 6;
  localparam int PRE_BIT_4  = 1;
  localparam int PRE_BIT_16 = 3;
  localparam int PRE_BIT_64 = 5;
endpackage : tpp_pkg
`default_nettype wire

// ### hw/tpp_top.sv
// Timer channel 0 with compare match flags driving two latched pulse pattern output groups
`default_nettype none
module tpp_top
  import tpp_pkg::*;
(
  input  wire logic              clk_sys,       // System clock, 40 MHz
  input  wire logic              sys_rst,       // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] reg_addr,      // Register byte address
  input  wire logic [DATA_W-1:0] reg_wdata,     // Register write data
  input  wire logic              reg_wr,        // Write strobe
  input  wire logic              reg_rd,        // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,     // Read data, cycle after strobe
  input  wire logic              ext_clk_in,    // External count clock
  output logic      [7:0]        pulse_out,     // Pulse pattern to motor stage
  output logic                   compare_a_irq, // Compare A request
  output logic                   irq            // Combined request of flags whose enable bit is 1
);

  // All state of the block
  typedef struct packed {
    logic [PRE_W-1:0]  pre;
    logic              ext;
    logic [15:0]       counter0;
    logic [15:0]       cmp_a;
    logic [15:0]       cmp_b;
    logic [7:0]        ctrl;
    logic [7:0]        run;
    logic [7:0]        ien;
    logic [1:0]        flags;
    logic [7:0]        next_val;
    logic [7:0]        next_en;
    logic [7:0]        out_data;
    logic [7:0]        trig_sel;
    logic [DATA_W-1:0] rdata;
    logic              irq_a;
    logic              irq;
  } tpp_state_t;

  tpp_state_t s_q;
  tpp_state_t s_d;

  logic [PRE_W-1:0] pre_inc;
  logic [2:0]       psc;
  logic [1:0]       edge_sel;
  logic [2:0]       clr_sel;
  logic             int_fall;
  logic             int_rise;
  logic             ext_rise;
  logic             ext_fall;
  logic             tick;
  logic             match_a;
  logic             match_b;
  logic [1:0]       clear_mask;
  logic [7:0]       trig_bits;
  logic [7:0]       wr_mask;
  int               bsel;

  assign pre_inc  = s_q.pre + PRE_W'(1);
  assign psc      = s_q.ctrl[PRESCALE_SELECT_LSB +: 3];
  assign edge_sel = s_q.ctrl[CLOCK_EDGE_SELECT_LSB +: 2];
  assign clr_sel  = s_q.ctrl[COUNTER_CLEAR_SELECT_LSB +: 3];

  // Edges of the divided internal clock and of the external clock
  always_comb
  begin
    bsel = PRE_BIT_16;
    case (psc)
      PSC_4:   bsel = PRE_BIT_4;
      PSC_16:  bsel = PRE_BIT_16;
      PSC_64:  bsel = PRE_BIT_64;
      default: bsel = PRE_BIT_16;
    endcase
    int_fall = s_q.pre[bsel] & ~pre_inc[bsel];
    int_rise = ~s_q.pre[bsel] & pre_inc[bsel];
    ext_rise = ext_clk_in & ~s_q.ext;
    ext_fall = ~ext_clk_in & s_q.ext;
  end

  // Count tick: undivided clock counts every cycle, codes 1xx pick the pin
  always_comb
  begin
    tick = 1'b0;
    if (psc == PSC_1)
      tick = 1'b1;
    else if (psc[2])
    begin
      case (edge_sel)
        EDGE_FALL: tick = ext_rise;
        EDGE_RISE: tick = ext_fall;
        default:   tick = ext_rise | ext_fall;
      endcase
    end
    else
    begin
      case (edge_sel)
        EDGE_FALL: tick = int_fall;
        EDGE_RISE: tick = int_rise;
        default:   tick = int_fall | int_rise;
      endcase
    end
  end

  // A match is taken once, at the count edge that ends the equal period
  assign match_a = s_q.run[RUN_BIT] & tick & (s_q.counter0 == s_q.cmp_a);
  assign match_b = s_q.run[RUN_BIT] & tick & (s_q.counter0 == s_q.cmp_b);

  // Output trigger per group of four bits; only channel 0 exists here
  generate
    for (genvar g = 0; g < GRP_FIELDS; g++)
    begin : g_trig
      assign trig_bits[g*GRP_BITS +: GRP_BITS] =
        {GRP_BITS{(s_q.trig_sel[g*2 +: 2] == TRIG_CH0) & match_a}};
    end
  endgenerate

  // Flags cleared by writing one; a match in the same cycle wins
  assign clear_mask = (reg_wr && reg_addr == ADR_MATCH_FLAGS) ? reg_wdata[1:0] : 2'h0;

  // Enabled bits are shielded from software writes
  assign wr_mask = ~s_q.next_en;

  // Next state
  always_comb
  begin
    s_d     = s_q;
    s_d.pre = pre_inc;
    s_d.ext = ext_clk_in;

    // Counter: hold while stopped, clear on selected match, else step and wrap
    if (s_q.run[RUN_BIT] && tick)
    begin
      if ((clr_sel == COUNTER_CLEAR_SELECT_B && match_b) || (clr_sel == COUNTER_CLEAR_SELECT_A && match_a))
        s_d.counter0 = 16'h0000;
      else
        s_d.counter0 = s_q.counter0 + 16'h0001;
    end

    s_d.flags[FLAG_A] = (s_q.flags[FLAG_A] & ~clear_mask[FLAG_A]) | match_a;
    s_d.flags[FLAG_B] = (s_q.flags[FLAG_B] & ~clear_mask[FLAG_B]) | match_b;

    // Software writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADR_COMPARE_A:   s_d.cmp_a    = reg_wdata;
        ADR_COMPARE_B:   s_d.cmp_b    = reg_wdata;
        ADR_NEXT_ENABLE: s_d.next_en  = reg_wdata[7:0];
        ADR_OUTPUT_DATA: s_d.out_data = (s_q.out_data & ~wr_mask) | (reg_wdata[7:0] & wr_mask);
        ADR_NEXT_VALUE:  s_d.next_val = reg_wdata[7:0];
        ADR_TRIG_SELECT: s_d.trig_sel = reg_wdata[7:0];
        ADR_RUN_CONTROL: s_d.run      = reg_wdata[7:0];
        ADR_CONTROL:     s_d.ctrl     = reg_wdata[7:0];
        ADR_IRQ_ENABLE:  s_d.ien      = reg_wdata[7:0];
        default:         s_d.run      = s_q.run;
      endcase
    end

    // Trigger copies enabled bits only and overrides a same-cycle write
    s_d.out_data = (s_d.out_data & ~(trig_bits & s_q.next_en))
                 | (s_q.next_val & trig_bits & s_q.next_en);

    // Read data stand only in the cycle after the strobe
    s_d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        ADR_MATCH_FLAGS: s_d.rdata = {14'h0000, s_q.flags};
        ADR_COMPARE_A:   s_d.rdata = s_q.cmp_a;
        ADR_COMPARE_B:   s_d.rdata = s_q.cmp_b;
        ADR_NEXT_ENABLE: s_d.rdata = {8'h00, s_q.next_en};
        ADR_OUTPUT_DATA: s_d.rdata = {8'h00, s_q.out_data};
        ADR_NEXT_VALUE:  s_d.rdata = {8'h00, s_q.next_val};
        ADR_TRIG_SELECT: s_d.rdata = {8'h00, s_q.trig_sel};
        ADR_RUN_CONTROL: s_d.rdata = {8'h00, s_q.run};
        ADR_CONTROL:     s_d.rdata = {8'h00, s_q.ctrl};
        ADR_IRQ_ENABLE:  s_d.rdata = {8'h00, s_q.ien};
        default:         s_d.rdata = '0;
      endcase
    end

    // Requests follow the flags of the next state so they leave flops
    s_d.irq_a = s_d.flags[FLAG_A] & s_d.ien[FLAG_A];
    s_d.irq   = |(s_d.flags & s_d.ien[1:0]);
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q          <= '0;
      s_q.cmp_a    <= RST_COMPARE;
      s_q.cmp_b    <= RST_COMPARE;
      s_q.trig_sel <= RST_TRIG_SELECT;
      s_q.ctrl     <= RST_BYTE;
      s_q.run      <= RST_BYTE;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata     = s_q.rdata;
  assign pulse_out     = s_q.out_data;
  assign compare_a_irq = s_q.irq_a;
  assign irq           = s_q.irq;

endmodule // tpp_top
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the pulse pattern block
`default_nettype none
module tb;
  import tpp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [23:0] reg_addr = 24'h000000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ext_clk_in = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0]  pulse_out;
  logic [7:0]  coil_q;
  logic        compare_a_irq;
  logic        irq;
  int          failures = 0;
  int          comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  tpp_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
    .pulse_out(pulse_out), .compare_a_irq(compare_a_irq), .irq(irq));
  tpp_motor_stage stage (.clk_sys(clk_sys), .pulse_out(pulse_out), .coil_q(coil_q));
  // Counts and verdict
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [23:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_irq(input int lim);
    for (int n = 0; n < lim && irq !== 1'b1; n++) @(posedge clk_sys);
    if (irq !== 1'b1)
    begin
      chk({15'h0000, irq}, 16'h0001);
      complete_run();
    end
  endtask
  // External count clock: each pulse is two cycles high, two low
  task automatic ext_pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      ext_clk_in <= 1'b1;
      repeat (2) @(posedge clk_sys);
      ext_clk_in <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADR_COMPARE_A, 16'hFFFF);
    rd(ADR_TRIG_SELECT, 16'h00FF);
    rd(24'hFFFFC7, 16'h0000);
    wr(ADR_COMPARE_B, 16'hA55A);
    rd(ADR_COMPARE_B, 16'hA55A);
    wr(ADR_OUTPUT_DATA, 16'h0009);
    rd(ADR_OUTPUT_DATA, 16'h0009);
    wr(ADR_NEXT_ENABLE, 16'h000F);
    wr(ADR_OUTPUT_DATA, 16'h0056);
    rd(ADR_OUTPUT_DATA, 16'h0059);
    $display("Preset test done");
    // Group 1 left untriggered so its nibble must hold
    wr(ADR_NEXT_VALUE, 16'h00FC);
    wr(ADR_TRIG_SELECT, 16'h00E4);
    wr(ADR_COMPARE_A, 16'h0004);
    wr(ADR_CONTROL, 16'h0020);
    wr(ADR_IRQ_ENABLE, 16'h0001);
    wr(ADR_RUN_CONTROL, 16'h0001);
    wait_irq(100);
    #1 chk({15'h0000, compare_a_irq}, 16'h0001);
    wr(ADR_RUN_CONTROL, 16'h0000);
    #1 chk({8'h00, pulse_out}, 16'h005C);
    rd(ADR_MATCH_FLAGS, 16'h0001);
    wr(ADR_MATCH_FLAGS, 16'h0001);
    rd(ADR_MATCH_FLAGS, 16'h0000);
    chk({15'h0000, compare_a_irq}, 16'h0000);
    repeat (20) @(posedge clk_sys);
    rd(ADR_MATCH_FLAGS, 16'h0000);
    $display("Trigger test done");
    wr(ADR_IRQ_ENABLE, 16'h0000);
    wr(ADR_RUN_CONTROL, 16'h0001);
    repeat (20) @(posedge clk_sys);
    rd(ADR_MATCH_FLAGS, 16'h0001);
    chk({14'h0000, compare_a_irq, irq}, 16'h0000);
    wr(ADR_RUN_CONTROL, 16'h0000);
    wr(ADR_MATCH_FLAGS, 16'h0003);
    $display("Mask test done");
    // Counter sits at 0..4, so B at 5 is met before A at 6
    wr(ADR_COMPARE_A, 16'h0006);
    wr(ADR_COMPARE_B, 16'h0005);
    wr(ADR_CONTROL, 16'h0042);
    wr(ADR_IRQ_ENABLE, 16'h0002);
    wr(ADR_RUN_CONTROL, 16'h0001);
    repeat (12) @(posedge clk_sys);
    #1 chk({15'h0000, irq}, 16'h0000);
    wait_irq(300);
    wr(ADR_RUN_CONTROL, 16'h0000);
    rd(ADR_MATCH_FLAGS, 16'h0002);
    chk({8'h00, coil_q}, 16'h005C);
    $display("Clear test done");
    // Counter was cleared by the B match and stopped before its next tick, so it starts at 0
    wr(ADR_MATCH_FLAGS, 16'h0002);
    wr(ADR_CONTROL, 16'h0044);
    wr(ADR_RUN_CONTROL, 16'h0001);
    ext_pulse(5);
    repeat (2) @(posedge clk_sys);
    #1 chk({15'h0000, irq}, 16'h0000);
    // Sixth rising edge meets B while the pin is still high
    @(posedge clk_sys);
    ext_clk_in <= 1'b1;
    wait_irq(4);
    ext_clk_in <= 1'b0;
    wr(ADR_RUN_CONTROL, 16'h0000);
    rd(ADR_MATCH_FLAGS, 16'h0002);
    $display("External clock test done");
    complete_run();
  end
endmodule // tb
bind tpp_top tpp_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_clk_in(ext_clk_in), .pulse_out(pulse_out), .compare_a_irq(compare_a_irq), .irq(irq));
`default_nettype wire

// ### verif/tpp_motor_stage.sv
// Behavioural motor drive stage on the pulse outputs
`default_nettype none
module tpp_motor_stage
(
  input  wire logic       clk_sys,   // Clock
  input  wire logic [7:0] pulse_out, // Coil drive
  output logic      [7:0] coil_q     // Coils energised
);
  timeunit 1ns;
  timeprecision 100ps;
  // Coils follow a cycle late, as a power stage would
  always_ff @(posedge clk_sys)
  begin
    coil_q <= pulse_out;
  end
endmodule // tpp_motor_stage
`default_nettype wire

// ### verif/tpp_props.sv
// Port-level properties of the pulse pattern block
`default_nettype none
module tpp_props
  import tpp_pkg::*;
(
  input wire logic              clk_sys,       // Clock
  input wire logic              sys_rst,       // Reset
  input wire logic [ADDR_W-1:0] reg_addr,      // Address
  input wire logic [DATA_W-1:0] reg_wdata,     // Write data
  input wire logic              reg_wr,        // Write
  input wire logic              reg_rd,        // Read
  input wire logic [DATA_W-1:0] reg_rdata,     // Read data
  input wire logic              ext_clk_in,    // Ext clock
  input wire logic [7:0]        pulse_out,     // Pattern
  input wire logic              compare_a_irq, // Request A
  input wire logic              irq            // Request
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [7:0] en_q;    // Next enable copy
  logic [7:0] irqen_q; // Irq enable copy
  logic       wr_out;  // Output data write
  assign wr_out = reg_wr && reg_addr == ADR_OUTPUT_DATA;
  // Copies follow bus writes, so no probe into the design is needed
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      en_q    <= 8'h00;
      irqen_q <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == ADR_NEXT_ENABLE) en_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == ADR_IRQ_ENABLE) irqen_q <= reg_wdata[7:0];
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 24'hFFFFC7 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (reg_rd && reg_addr[7:4] == 4'hC |=> reg_rdata[15:8] == 8'h00)
    else $error("byte register upper half set");
  a_a_masked: assert property (compare_a_irq |-> irqen_q[0] || $past(irqen_q[0]))
    else $error("masked request A raised");
  a_a_sticky: assert property ($fell(compare_a_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("request A dropped alone");
  a_irq_sticky: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("request dropped alone");
  a_out_hold: assert property (((pulse_out ^ $past(pulse_out)) & ~$past(en_q)) != 8'h00 |-> $past(wr_out))
    else $error("disabled output bit moved");
  a_out_preset: assert property (wr_out |=> ((pulse_out ^ $past(reg_wdata[7:0])) & ~$past(en_q)) == 8'h00)
    else $error("preset write lost");
  c_req_a: cover property ($rose(compare_a_irq));
  c_req_b: cover property ($rose(irq) && !compare_a_irq);
  c_step: cover property ($changed(pulse_out));
endmodule // tpp_props
`default_nettype wire
